// ==== rtl/rsw_defines.svh ====
// Purpose: constants of the two-channel stripe switch
// Assumes: one user clock, counts in 1024-bit words (128 bytes)
// Notes:   included by the counter selector and the top of the switch
// How it works
// - one channel per stripe, 512 bytes each
// - readiness check ends write on zero remaining
// - write starts on 512B source, 1024B free
// - write-buffer counts muxed, one clock later
// - write move lasts four clocks popping source
// - write data steered by select delayed two
// - move state computes next channel pointer
// - active channel toggles after every stripe
// - two stripes stored skip settle wait
// - settle waits three clocks, then check
// - read starts: length, 512B fill, 1024B free
// - receive fills muxed by next pointer
// - read pops active receive buffer four clocks
// - read data chosen by select delayed two
// - read loops while length remains, else wait
// - completion wait until all channels idle
// - next pointer picks examined receive fill
// - start index bit0 picks first channel
`ifndef RSW_DEFINES_SVH
`define RSW_DEFINES_SVH

// =====================================================
// commands
`define RSW_CMD_WRITE      3'h2
`define RSW_CMD_READ       3'h3

// =====================================================
// stripe geometry in 1024-bit words
`define RSW_STRIPE_WORDS   16'h0004
`define RSW_FREE_WORDS     16'h0008
`define RSW_TWO_STRIPES    16'h0008
`define RSW_LAST_BEAT      2'h3

// =====================================================
// timing
`define RSW_SETTLE_LAST    2'h2

// =====================================================
// reset values
`define RSW_RST_LEN        48'h0000_0000_0000
`define RSW_RST_CHAN       1'h0

`endif

// ==== rtl/rsw_pkg.sv ====
// Purpose: shared types of the stripe switch
// Assumes: nothing beyond the defines header
// Notes:   used by name, never imported
package rsw_pkg;

  // =====================================================
  // controller states
  typedef enum logic [2:0] {
    RSW_IDLE   = 3'h0,  // waiting for a command
    RSW_READY  = 3'h1,  // readiness check
    RSW_MOVE   = 3'h2,  // stripe move, four beats
    RSW_SETTLE = 3'h3,  // settle after a write stripe
    RSW_COMPL  = 3'h4   // completion wait on read
  } rsw_state_type;

endpackage : rsw_pkg

// ==== rtl/rsw_count_mux.sv ====
// Purpose: registered two-way selector for buffer counters
// Assumes: select is stable for a cycle before use
// Notes:   adds exactly one clock of latency
`timescale 1ns/1ps
`default_nettype none
`include "rsw_defines.svh"
module rsw_count_mux #(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // selection
  input  wire logic          i_sel,
  input  wire logic [CW-1:0] i_cnt0,
  input  wire logic [CW-1:0] i_cnt1,
  // selected count
  output logic      [CW-1:0] o_cnt
);

  // =====================================================
  // one registered stage keeps the compare path short
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cnt <= '0;
    end else begin
      o_cnt <= i_sel ? i_cnt1 : i_cnt0;
    end
  end

endmodule : rsw_count_mux
`default_nettype wire

// ==== rtl/rsw_word_mux.sv ====
// Purpose: read-side data gather from two receive buffers
// Assumes: words valid the cycle after their pop
// Notes:   two register stages, output from flops
`timescale 1ns/1ps
`default_nettype none
module rsw_word_mux #(
  parameter int DW = 1024
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // capture side, one cycle after a pop
  input  wire logic          i_take,
  input  wire logic [DW-1:0] i_word0,
  input  wire logic [DW-1:0] i_word1,
  // delayed channel select
  input  wire logic          i_sel,
  // toward the sink
  output logic               o_push,
  output logic      [DW-1:0] o_word
);

  logic          hold_v_q;   // captured pair is live
  logic [DW-1:0] hold0_q;    // channel 0 word
  logic [DW-1:0] hold1_q;    // channel 1 word

  // =====================================================
  // capture both channels, choose one a cycle later
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hold_v_q <= 1'b0;
    end else begin
      hold_v_q <= i_take;
    end
  end

  always_ff @(posedge i_clk) begin
    hold0_q <= i_word0;
    hold1_q <= i_word1;
  end

  // push and word to the sink fifo
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_push <= 1'b0;
      o_word <= '0;
    end else begin
      o_push <= hold_v_q;
      o_word <= i_sel ? hold1_q : hold0_q;
    end
  end

endmodule : rsw_word_mux
`default_nettype wire

// ==== rtl/rsw_top.sv ====
// Purpose: stripe switch between user fifos and two channels
// Assumes: fifo counts in 1024-bit words; inputs synchronous
// Notes:   one command at a time; busy flag guards requests
`timescale 1ns/1ps
`default_nettype none
`include "rsw_defines.svh"
module rsw_top #(
  parameter int          DW         = 1024,
  parameter int          CW         = 16,
  parameter logic [15:0] CHAN_DEPTH = 16'h0080,
  parameter logic [15:0] SINK_DEPTH = 16'hFFFF
) (
  // clock and reset
  input  wire logic          I_CLK,
  input  wire logic          I_RST_N,
  // command port
  input  wire logic          I_CMD_REQ,
  input  wire logic [2:0]    I_COMMAND_CODE,
  input  wire logic [47:0]   I_START_BLOCK_INDEX,
  input  wire logic [47:0]   I_XFER_LEN,
  output logic               O_ENGINE_BUSY_FLAG,
  // channel controller status
  input  wire logic [1:0]    I_CHANNEL_BUSY,
  // source fifo, write direction
  input  wire logic [CW-1:0] I_SOURCE_FIFO_LEVEL,
  input  wire logic [DW-1:0] I_SOURCE_FIFO_WORD,
  output logic               O_SOURCE_FIFO_POP,
  // channel write buffers
  input  wire logic [CW-1:0] I_CHANNEL_WRITE_BUFFER_COUNT0,
  input  wire logic [CW-1:0] I_CHANNEL_WRITE_BUFFER_COUNT1,
  output logic      [1:0]    O_CHANNEL_WRITE_BUFFER_PUSH,
  output logic      [DW-1:0] O_CHANNEL_WRITE_BUFFER_WORD,
  // channel receive buffers
  input  wire logic [CW-1:0] I_CHANNEL_RECEIVE_BUFFER_FILL0,
  input  wire logic [CW-1:0] I_CHANNEL_RECEIVE_BUFFER_FILL1,
  input  wire logic [DW-1:0] I_CHANNEL_RECEIVE_BUFFER_WORD0,
  input  wire logic [DW-1:0] I_CHANNEL_RECEIVE_BUFFER_WORD1,
  output logic      [1:0]    O_CHANNEL_RECEIVE_BUFFER_POP,
  // sink fifo, read direction
  input  wire logic [CW-1:0] I_SINK_FIFO_COUNT,
  output logic               O_SINK_FIFO_PUSH,
  output logic      [DW-1:0] O_SINK_FIFO_WORD
);

  // =====================================================
  // helpers

  // one-hot strobe for a channel number
  function automatic logic [1:0] chan_hot(input logic ch);
    chan_hot = ch ? 2'b10 : 2'b01;
  endfunction : chan_hot

  // true when a buffer of given depth has room for need
  function automatic logic has_room(input logic [15:0] cnt,
                                    input logic [15:0] depth,
                                    input logic [15:0] need);
    has_room = (cnt <= depth) && ((depth - cnt) >= need);
  endfunction : has_room

  // =====================================================
  // state

  rsw_pkg::rsw_state_type state_q;  // controller state
  rsw_pkg::rsw_state_type state_d;  // its next value
  logic        rd_dir_q;            // 1: read, 0: write
  logic [47:0] remain_q;            // stripes still to move
  logic [1:0]  beat_q;              // beat within a stripe
  logic [1:0]  settle_q;            // settle wait counter
  logic        active_q;            // select, pipe stage 0
  logic        pipe1_q;             // select, one clock late
  logic        pipe2_q;             // select, two clocks late
  logic        next_ptr_q;          // channel to examine next

  // write data path stages
  logic          src_pop_d1_q;      // pop seen last cycle
  logic          stage_v_q;         // staged word is live
  logic [DW-1:0] stage_word_q;      // staged source word

  // read capture strobe, one cycle after a pop
  logic          rcv_take_q;

  // selected counters, one clock behind their sources
  logic [CW-1:0] sel_wcount;        // write buffer count
  logic [CW-1:0] sel_rfill;         // receive buffer fill

  // decoded conditions
  logic cmd_ok;                     // accepted command code
  logic last_beat;                  // fourth move beat
  logic src_ok;                     // source holds a stripe
  logic src_two;                    // source holds two
  logic wbuf_ok;                    // write buffer has room
  logic rbuf_ok;                    // receive buffer has one
  logic sink_ok;                    // sink fifo has room

  // =====================================================
  // counter selectors, steered by the next pointer
  rsw_count_mux #(
    .CW      (CW)
  ) u_wcount_mux (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sel   (next_ptr_q),
    .i_cnt0  (I_CHANNEL_WRITE_BUFFER_COUNT0),
    .i_cnt1  (I_CHANNEL_WRITE_BUFFER_COUNT1),
    .o_cnt   (sel_wcount)
  );

  rsw_count_mux #(
    .CW      (CW)
  ) u_rfill_mux (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sel   (next_ptr_q),
    .i_cnt0  (I_CHANNEL_RECEIVE_BUFFER_FILL0),
    .i_cnt1  (I_CHANNEL_RECEIVE_BUFFER_FILL1),
    .o_cnt   (sel_rfill)
  );

  // =====================================================
  // condition decode
  always_comb begin
    cmd_ok    = (I_COMMAND_CODE == `RSW_CMD_WRITE) ||
                (I_COMMAND_CODE == `RSW_CMD_READ);
    last_beat = (beat_q == `RSW_LAST_BEAT);
    // direct source level against the delayed channel count
    src_ok    = I_SOURCE_FIFO_LEVEL[15:0] >= `RSW_STRIPE_WORDS;
    src_two   = I_SOURCE_FIFO_LEVEL[15:0] >= `RSW_TWO_STRIPES;
    wbuf_ok   = has_room(sel_wcount[15:0], CHAN_DEPTH,
                         `RSW_FREE_WORDS);
    rbuf_ok   = sel_rfill[15:0] >= `RSW_STRIPE_WORDS;
    sink_ok   = has_room(I_SINK_FIFO_COUNT[15:0], SINK_DEPTH,
                         `RSW_FREE_WORDS);
  end

  // =====================================================
  // next-state logic
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rsw_pkg::RSW_IDLE: begin
        // unknown codes are ignored, busy stays low
        if (I_CMD_REQ && cmd_ok) begin
          state_d = rsw_pkg::RSW_READY;
        end
      end
      rsw_pkg::RSW_READY: begin
        if (remain_q == 48'h0) begin
          // write ends at once; read drains the channels
          state_d = rd_dir_q ? rsw_pkg::RSW_COMPL
                             : rsw_pkg::RSW_IDLE;
        end else if (!rd_dir_q && src_ok && wbuf_ok) begin
          state_d = rsw_pkg::RSW_MOVE;
        end else if (rd_dir_q && rbuf_ok && sink_ok) begin
          state_d = rsw_pkg::RSW_MOVE;
        end
      end
      rsw_pkg::RSW_MOVE: begin
        if (last_beat) begin
          if (rd_dir_q) begin
            // read loops back to check the next channel
            state_d = rsw_pkg::RSW_READY;
          end else if (src_two) begin
            // level still covers a stripe after this one
            state_d = rsw_pkg::RSW_READY;
          end else begin
            state_d = rsw_pkg::RSW_SETTLE;
          end
        end
      end
      rsw_pkg::RSW_SETTLE: begin
        // level is stale while pops are in flight
        if (settle_q == `RSW_SETTLE_LAST) begin
          state_d = rsw_pkg::RSW_READY;
        end
      end
      rsw_pkg::RSW_COMPL: begin
        if (I_CHANNEL_BUSY == 2'h0) begin
          state_d = rsw_pkg::RSW_IDLE;
        end
      end
      default: begin
        // illegal code recovers to idle
        state_d = rsw_pkg::RSW_IDLE;
      end
    endcase
  end

  // =====================================================
  // state register and busy flag
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_q            <= rsw_pkg::RSW_IDLE;
      O_ENGINE_BUSY_FLAG <= 1'b0;
    end else begin
      state_q            <= state_d;
      O_ENGINE_BUSY_FLAG <= (state_d != rsw_pkg::RSW_IDLE);
    end
  end

  // =====================================================
  // command capture and remaining length
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rd_dir_q <= 1'b0;
      remain_q <= `RSW_RST_LEN;
    end else if (state_q == rsw_pkg::RSW_IDLE &&
                 I_CMD_REQ && cmd_ok) begin
      rd_dir_q <= (I_COMMAND_CODE == `RSW_CMD_READ);
      remain_q <= I_XFER_LEN;
    end else if (state_q == rsw_pkg::RSW_MOVE && last_beat) begin
      remain_q <= remain_q - 48'h1;
    end
  end

  // =====================================================
  // beat and settle counters
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      beat_q <= 2'h0;
    end else if (state_q == rsw_pkg::RSW_MOVE) begin
      // wraps to zero after the fourth beat
      beat_q <= beat_q + 2'h1;
    end else begin
      beat_q <= 2'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      settle_q <= 2'h0;
    end else if (state_q == rsw_pkg::RSW_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end else begin
      settle_q <= 2'h0;
    end
  end

  // =====================================================
  // active channel and its delayed copies
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      active_q <= `RSW_RST_CHAN;
    end else if (state_q == rsw_pkg::RSW_IDLE &&
                 I_CMD_REQ && cmd_ok) begin
      active_q <= I_START_BLOCK_INDEX[0];
    end else if (state_q == rsw_pkg::RSW_MOVE && last_beat) begin
      // stripe done, hand over to the other channel
      active_q <= ~active_q;
    end
  end

  // delay line lines the select up with the data
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pipe1_q <= `RSW_RST_CHAN;
      pipe2_q <= `RSW_RST_CHAN;
    end else begin
      pipe1_q <= active_q;
      pipe2_q <= pipe1_q;
    end
  end

  // =====================================================
  // next channel pointer feeding both counter selectors
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      next_ptr_q <= `RSW_RST_CHAN;
    end else if (state_q == rsw_pkg::RSW_IDLE &&
                 I_CMD_REQ && cmd_ok) begin
      next_ptr_q <= I_START_BLOCK_INDEX[0];
    end else if (state_q == rsw_pkg::RSW_MOVE) begin
      // look ahead so the count is ready at the check
      next_ptr_q <= ~active_q;
    end
  end

  // =====================================================
  // pop strobes, aligned with the move state
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_SOURCE_FIFO_POP            <= 1'b0;
      O_CHANNEL_RECEIVE_BUFFER_POP <= 2'h0;
    end else begin
      O_SOURCE_FIFO_POP <= (state_d == rsw_pkg::RSW_MOVE) &&
                           !rd_dir_q;
      // only the active channel is touched per stripe
      O_CHANNEL_RECEIVE_BUFFER_POP <=
        ((state_d == rsw_pkg::RSW_MOVE) && rd_dir_q) ?
        chan_hot(active_q) : 2'h0;
    end
  end

  // =====================================================
  // write data path: pop, capture, steer
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      src_pop_d1_q <= 1'b0;
      stage_v_q    <= 1'b0;
    end else begin
      src_pop_d1_q <= O_SOURCE_FIFO_POP;
      // word is valid the cycle after its pop
      stage_v_q    <= src_pop_d1_q;
    end
  end

  always_ff @(posedge I_CLK) begin
    stage_word_q <= I_SOURCE_FIFO_WORD;
  end

  // push only the channel the delayed select names
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_CHANNEL_WRITE_BUFFER_PUSH <= 2'h0;
      O_CHANNEL_WRITE_BUFFER_WORD <= '0;
    end else begin
      O_CHANNEL_WRITE_BUFFER_PUSH <=
        stage_v_q ? chan_hot(pipe2_q) : 2'h0;
      O_CHANNEL_WRITE_BUFFER_WORD <= stage_word_q;
    end
  end

  // =====================================================
  // read data path: capture one cycle after the pop
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rcv_take_q <= 1'b0;
    end else begin
      rcv_take_q <= |O_CHANNEL_RECEIVE_BUFFER_POP;
    end
  end

  // gather, selected by the two-clock delayed channel
  rsw_word_mux #(
    .DW      (DW)
  ) u_word_mux (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_take  (rcv_take_q),
    .i_word0 (I_CHANNEL_RECEIVE_BUFFER_WORD0),
    .i_word1 (I_CHANNEL_RECEIVE_BUFFER_WORD1),
    .i_sel   (pipe2_q),
    .o_push  (O_SINK_FIFO_PUSH),
    .o_word  (O_SINK_FIFO_WORD)
  );

endmodule : rsw_top
`default_nettype wire

// ==== sim/rsw_far_model.sv ====
// Purpose: far-side data model of the user and channel fifos
// Assumes: bench drives counts, model drives data
// Notes:   stale words are inverted so a late sample is caught
`timescale 1ns/1ps
`default_nettype none
module rsw_far_model #(
  parameter int DW = 1024
) (
  // clock
  input  wire logic          i_clk,
  // read strobes from the switch
  input  wire logic          i_src_pop,
  input  wire logic [1:0]    i_rx_pop,
  // data words
  output logic      [DW-1:0] o_src_word,
  output logic      [DW-1:0] o_rx_word0,
  output logic      [DW-1:0] o_rx_word1
);
  // ==========
  // data generation
  logic [31:0] seq_q = 32'h0000_0001;  // word tag
  // word valid after a pop, else inverted
  always @(posedge i_clk) begin
    seq_q      <= seq_q + 32'h0000_0001;
    o_src_word <= i_src_pop ? {(DW/32){seq_q}} : ~o_src_word;
    o_rx_word0 <= i_rx_pop[0] ? {(DW/32){seq_q ^ 32'h00A0_0000}}
                              : ~o_rx_word0;
    o_rx_word1 <= i_rx_pop[1] ? {(DW/32){seq_q ^ 32'h0B00_0000}}
                              : ~o_rx_word1;
  end
endmodule : rsw_far_model
`default_nettype wire

// ==== sim/rsw_top_asserts.sv ====
// Purpose: port-level checks of the stripe switch
// Assumes: counts in 1024-bit words, one clock
// Notes:   bound into every rsw_top instance
`timescale 1ns/1ps
`default_nettype none
module rsw_top_asserts #(
  parameter int          DW         = 1024,
  parameter int          CW         = 16,
  parameter logic [15:0] SINK_DEPTH = 16'hFFFF
) (
  // clock, reset, command
  input wire logic          I_CLK,
  input wire logic          I_RST_N,
  input wire logic          I_CMD_REQ,
  input wire logic [2:0]    I_COMMAND_CODE,
  input wire logic [1:0]    I_CHANNEL_BUSY,
  input wire logic          O_ENGINE_BUSY_FLAG,
  // write path
  input wire logic [CW-1:0] I_SOURCE_FIFO_LEVEL,
  input wire logic [DW-1:0] I_SOURCE_FIFO_WORD,
  input wire logic          O_SOURCE_FIFO_POP,
  input wire logic [1:0]    O_CHANNEL_WRITE_BUFFER_PUSH,
  input wire logic [DW-1:0] O_CHANNEL_WRITE_BUFFER_WORD,
  // read path
  input wire logic [DW-1:0] I_CHANNEL_RECEIVE_BUFFER_WORD0,
  input wire logic [DW-1:0] I_CHANNEL_RECEIVE_BUFFER_WORD1,
  input wire logic [1:0]    O_CHANNEL_RECEIVE_BUFFER_POP,
  input wire logic [CW-1:0] I_SINK_FIFO_COUNT,
  input wire logic          O_SINK_FIFO_PUSH,
  input wire logic [DW-1:0] O_SINK_FIFO_WORD
);
  // ==========
  // one clock domain for every check
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic rd_q;  // accepted command is a read
  // kind of accepted command
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) rd_q <= 1'b0;
    else if (!O_ENGINE_BUSY_FLAG && I_CMD_REQ) rd_q <= I_COMMAND_CODE[0];
  end
  // ==========
  // write direction
  src_burst_a: assert property (
    $rose(O_SOURCE_FIFO_POP) |-> O_SOURCE_FIFO_POP[*4] ##1 !O_SOURCE_FIFO_POP)
    else $error("source pop not 4 long");
  src_gate_a: assert property (
    $rose(O_SOURCE_FIFO_POP) |-> $past(I_SOURCE_FIFO_LEVEL) >= 16'h0004)
    else $error("write start without stripe");
  wdata_path_a: assert property (
    O_SOURCE_FIFO_POP |-> ##3 (|O_CHANNEL_WRITE_BUFFER_PUSH) &&
      O_CHANNEL_WRITE_BUFFER_WORD == $past(I_SOURCE_FIFO_WORD, 2))
    else $error("write word wrong");
  wpush_stripe_a: assert property (
    $rose(|O_CHANNEL_WRITE_BUFFER_PUSH) |-> $onehot(O_CHANNEL_WRITE_BUFFER_PUSH)
      ##1 $stable(O_CHANNEL_WRITE_BUFFER_PUSH)[*3])
    else $error("write stripe split");
  settle_gap_a: assert property (
    $fell(O_SOURCE_FIFO_POP) && $past(I_SOURCE_FIFO_LEVEL) < 16'h0008
      |-> (!O_SOURCE_FIFO_POP)[*4])
    else $error("settle wait short");
  // ==========
  // read direction
  rx_burst_a: assert property (
    $rose(|O_CHANNEL_RECEIVE_BUFFER_POP) |-> $onehot(O_CHANNEL_RECEIVE_BUFFER_POP)
      ##1 $stable(O_CHANNEL_RECEIVE_BUFFER_POP)[*3] ##1 !(|O_CHANNEL_RECEIVE_BUFFER_POP))
    else $error("receive pop not 4 long");
  rx_gate_a: assert property (
    $rose(|O_CHANNEL_RECEIVE_BUFFER_POP)
      |-> $past(I_SINK_FIFO_COUNT) <= SINK_DEPTH - 16'h0008)
    else $error("read start without room");
  sink_path_a: assert property (
    (|O_CHANNEL_RECEIVE_BUFFER_POP) |-> ##3 O_SINK_FIFO_PUSH &&
      O_SINK_FIFO_WORD == ($past(O_CHANNEL_RECEIVE_BUFFER_POP[1], 3)
        ? $past(I_CHANNEL_RECEIVE_BUFFER_WORD1, 2)
        : $past(I_CHANNEL_RECEIVE_BUFFER_WORD0, 2)))
    else $error("sink word wrong");
  compl_wait_a: assert property (
    $fell(O_ENGINE_BUSY_FLAG) && rd_q |-> $past(I_CHANNEL_BUSY) == 2'h0)
    else $error("read ended while busy");
  // ==========
  // command acceptance
  busy_start_a: assert property (
    !O_ENGINE_BUSY_FLAG && I_CMD_REQ && I_COMMAND_CODE[2:1] == 2'h1
      |=> O_ENGINE_BUSY_FLAG)
    else $error("valid command not taken");
  bad_code_a: assert property (
    !O_ENGINE_BUSY_FLAG && I_CMD_REQ && I_COMMAND_CODE[2:1] != 2'h1
      |=> !O_ENGINE_BUSY_FLAG)
    else $error("bad code made busy");
endmodule : rsw_top_asserts
bind rsw_top rsw_top_asserts #(.DW(DW), .CW(CW),
  .SINK_DEPTH(SINK_DEPTH)) chk_u (.*);
`default_nettype wire

// ==== sim/rsw_top_bench.sv ====
// Purpose: self-checking bench of the stripe switch
// Assumes: default depths, counts in 1024-bit words
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module rsw_top_bench;
  localparam int DW = 1024;
  localparam int CW = 16;
  // ==========
  // stimulus and observed signals
  logic          clk, rst_n, req, busy, src_pop, sink_push;
  logic [2:0]    code;
  logic [47:0]   idx, len;
  logic [1:0]    ch_busy, wpush, rx_pop, rx_pop_d;
  logic [CW-1:0] src_lvl, wcnt0, wcnt1, fill0, fill1, sink_cnt;
  logic [DW-1:0] src_word, wword, rxw0, rxw1, sink_word;
  logic [DW-1:0] sq[$], rq[$];  // words taken from the far side
  logic          fc, src_pop_d;  // first channel, last-cycle pop
  int            seed, mismatches, n_tests, cyc, wb, rb, sb, gap, last_rise;
  rsw_top dut_u (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CMD_REQ(req), .I_COMMAND_CODE(code),
    .I_START_BLOCK_INDEX(idx), .I_XFER_LEN(len), .O_ENGINE_BUSY_FLAG(busy),
    .I_CHANNEL_BUSY(ch_busy), .I_SOURCE_FIFO_LEVEL(src_lvl),
    .I_SOURCE_FIFO_WORD(src_word), .O_SOURCE_FIFO_POP(src_pop),
    .I_CHANNEL_WRITE_BUFFER_COUNT0(wcnt0),
    .I_CHANNEL_WRITE_BUFFER_COUNT1(wcnt1),
    .O_CHANNEL_WRITE_BUFFER_PUSH(wpush), .O_CHANNEL_WRITE_BUFFER_WORD(wword),
    .I_CHANNEL_RECEIVE_BUFFER_FILL0(fill0),
    .I_CHANNEL_RECEIVE_BUFFER_FILL1(fill1),
    .I_CHANNEL_RECEIVE_BUFFER_WORD0(rxw0),
    .I_CHANNEL_RECEIVE_BUFFER_WORD1(rxw1),
    .O_CHANNEL_RECEIVE_BUFFER_POP(rx_pop), .I_SINK_FIFO_COUNT(sink_cnt),
    .O_SINK_FIFO_PUSH(sink_push), .O_SINK_FIFO_WORD(sink_word));
  rsw_far_model #(.DW(DW)) far_u (
    .i_clk(clk), .i_src_pop(src_pop), .i_rx_pop(rx_pop),
    .o_src_word(src_word), .o_rx_word0(rxw0), .o_rx_word1(rxw1));
  // 50 MHz clock
  always #10 clk = ~clk;
  // ==========
  // compare tasks
  task automatic chk_v(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_v
  task automatic chk_w(input logic [DW-1:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s word differs", $time, what);
    end
  endtask : chk_w
  // ==========
  // monitor: channel order, data order and stripe spacing
  always @(posedge clk) begin
    cyc++;
    if (src_pop_d) sq.push_back(src_word);
    if (rx_pop_d[0]) rq.push_back(rxw0);
    else if (rx_pop_d[1]) rq.push_back(rxw1);
    if ((src_pop && !src_pop_d) || (|rx_pop && !(|rx_pop_d))) begin
      if (gap != 0 && last_rise >= 0)
        chk_v(16'(cyc - last_rise), 16'(gap), "spacing");
      last_rise = cyc;
    end
    if (|wpush) begin
      chk_v(16'(wpush), 16'((fc ^ wb[2]) ? 2'h2 : 2'h1), "wchan");
      chk_w(wword, sq.size() != 0 ? sq.pop_front() : 'x, "wdata");
      wb++;
    end
    if (|rx_pop) begin
      chk_v(16'(rx_pop), 16'((fc ^ rb[2]) ? 2'h2 : 2'h1), "rchan");
      rb++;
    end
    if (sink_push) begin
      chk_w(sink_word, rq.size() != 0 ? rq.pop_front() : 'x, "rdata");
      sb++;
    end
    src_pop_d = src_pop;
    rx_pop_d  = rx_pop;
  end
  // ==========
  // command tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic start(input logic [2:0] c, input logic [47:0] a, l,
                       input int g);
    int k;
    wb = 0; rb = 0; sb = 0; last_rise = -1; gap = g; fc = a[0];
    sq.delete();
    rq.delete();
    code = c; idx = a; len = l; req = 1'b1;
    k = 0;
    tick(1);
    while (busy !== 1'b1 && k < 4) begin
      tick(1);
      k++;
    end
    req = 1'b0;
    chk_v(16'(busy), 16'h0001, "taken");
  endtask : start
  task automatic finish(input int n, input string name);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      tick(1);
      k++;
    end
    tick(8);  // write pipeline may still push after busy falls
    chk_v(16'(wb + sb), 16'(n * 4), "words moved");
    $display("test %s ended at %0t", name, $time);
  endtask : finish
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // watchdog, 20000 cycles
  initial begin
    #400000;
    mismatches++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end
  // ==========
  // main sequence
  initial begin
    seed = 49; clk = 0; rst_n = 0; req = 0; code = 0; idx = 0; len = 0;
    ch_busy = 0; src_lvl = 16'h0040; wcnt0 = 0; wcnt1 = 0; fill0 = 16'h0040;
    fill1 = 16'h0040; sink_cnt = 0; mismatches = 0; n_tests = 0; cyc = 0;
    gap = 0; last_rise = -1; src_pop_d = 0; rx_pop_d = 0; fc = 0;
    wb = 0; rb = 0; sb = 0;
    tick(5);
    chk_v(16'({busy, src_pop, wpush, rx_pop, sink_push}), 16'h0000, "rst");
    rst_n = 1;
    tick(1);
    start(3'h2, 48'h0, 48'h3, 5);
    finish(3, "write back-to-back");
    src_lvl = 16'h0006;
    start(3'h2, 48'h1, 48'h2, 8);
    finish(2, "write with settle");
    // held write: short source, then a full channel buffer
    src_lvl = 16'h0003; wcnt0 = 16'h0079; wcnt1 = 16'h0079;
    start(3'h2, 48'h0, 48'h1, 0);
    tick(10);
    chk_v(16'(sq.size()), 16'h0000, "held by level");
    src_lvl = 16'h0040;
    tick(10);
    chk_v(16'(sq.size()), 16'h0000, "held by space");
    wcnt0 = 16'h0078;
    finish(1, "write gated");
    wcnt1 = 0;
    start(3'h3, 48'h1, 48'h3, 5);
    finish(3, "read back-to-back");
    // held read: no sink space, then short fill, busy channel
    sink_cnt = 16'hFFF8; fill0 = 16'h0003; fill1 = 16'h0003; ch_busy = 2'h1;
    start(3'h3, 48'h1, 48'h1, 0);
    tick(10);
    sink_cnt = 16'hFFF7;
    tick(10);
    chk_v(16'(rb), 16'h0000, "held read");
    fill1 = 16'h0004;
    tick(20);
    chk_v(16'({busy, 5'(rb)}), 16'h0024, "wait idle");
    ch_busy = 0;
    finish(1, "read gated");
    fill0 = 16'h0040; fill1 = 16'h0040; sink_cnt = 0;
    start(3'h2, 48'h0, 48'h0, 0);
    finish(0, "write empty");
    // unknown codes are ignored
    for (int c = 0; c < 8; c++) begin
      if (c[2:1] != 2'h1) begin
        code = 3'(c); req = 1'b1;
        tick(1);
        chk_v(16'(busy), 16'h0000, "bad code");
        req = 1'b0;
        tick(1);
      end
    end
    // random commands with ready fifos
    repeat (10) begin
      src_lvl = 16'h0004 + 16'($random(seed) & 15);
      wcnt0 = 16'($random(seed) & 63); wcnt1 = 16'($random(seed) & 63);
      fill0 = 16'h0004 + 16'($random(seed) & 15);
      fill1 = 16'h0004 + 16'($random(seed) & 15);
      sink_cnt = 16'($random(seed) & 16'h0FFF);
      code = 3'h2 | 3'($random(seed) & 1);
      len = 48'h1 + 48'($random(seed) & 3);
      start(code, 48'($random(seed)), len, (code[0] || src_lvl > 7) ? 5 : 8);
      finish(int'(len), "random");
    end
    results();
  end
endmodule : rsw_top_bench
`default_nettype wire
